// >>> logic/sfm_pkg.sv
// Package: register map, field layout, reset values and carrier types
`default_nettype none
package sfm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_GAIN     = 8'h04;
  localparam logic [7:0] ADDR_IN_MON   = 8'h08;
  localparam logic [7:0] ADDR_OUT_MON  = 8'h0C;
  localparam logic [7:0] ADDR_EDGE     = 8'h10;
  localparam logic [7:0] ADDR_POS      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_IN_POL   = 8'h20;
  localparam logic [7:0] ADDR_IN_DEB   = 8'h24;
  localparam logic [7:0] ADDR_OUT_INV  = 8'h28;
  localparam logic [7:0] ADDR_OUT_STAB = 8'h2C;

  // Control register fields
  localparam int CTRL_SCALE_BIT  = 0;
  localparam int CTRL_NOTICE_BIT = 1;
  localparam int CTRL_PHASE_BIT  = 2;
  localparam int CTRL_W          = 3;

  // Interrupt status and mask fields
  localparam int IRQ_NOTICE_BIT = 0;
  localparam int IRQ_WRAP_BIT   = 1;
  localparam int IRQ_ALARM_BIT  = 2;
  localparam int IRQ_W          = 3;

  localparam int IN_W   = 6;
  localparam int OUT_W  = 3;
  localparam int GAIN_W = 14;
  localparam int TMR_W  = 16;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST     = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_RST     = 14'h2710;
  localparam logic [GAIN_W-1:0] GAIN_MAX     = 14'h2710;
  localparam logic [IN_W-1:0]   IN_POL_RST   = 6'h00;
  localparam logic [TMR_W-1:0]  IN_DEB_RST   = 16'h0000;
  localparam logic [OUT_W-1:0]  OUT_INV_RST  = 3'h0;
  localparam logic [TMR_W-1:0]  OUT_STAB_RST = 16'h0000;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;

  // Character sent on completion
  localparam logic [7:0] END_CHAR = 8'h21;

  // Conditioned control inputs, alarm clear in bit 0
  typedef struct packed {
    logic jog;
    logic jog_dir;
    logic integration_off;
    logic hold;
    logic emergency_stop;
    logic alarm_clear;
  } sfm_in_s;

  // Internal output states, in-operation in bit 0
  typedef struct packed {
    logic in_position;
    logic driver_ready;
    logic in_operation;
  } sfm_out_s;

  typedef enum logic [2:0] {
    CN_IDLE = 3'b001,
    CN_HOLD = 3'b010,
    CN_SEND = 3'b100
  } sfm_cn_e;
endpackage
`default_nettype wire

// >>> logic/sfm_sync.sv
// Three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sfm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  if (W < 1) begin : g_chk
    $error("sfm_sync width must be at least one");
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      q  <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule
`default_nettype wire

// >>> logic/sfm_top.sv
// Servo feedback, completion notice and function monitor block with APB
// Function
// RQ1: Scale direction picks position count sense
// RQ2: Scale direction leaves limits, feedback phase alone
// RQ3: Completion notice off by default, on sends
// RQ4: Notice is the single character exclamation
// RQ5: Notice waits until line entry finishes
// RQ6: Input monitors show inverted, debounced state
// RQ7: Output monitors precede stability timer, inversion
// RQ8: Alarm, stop, hold, integration monitors: one active
// RQ9: Jog direction monitor: zero plus, one minus
// RQ10: Jog monitor: one accelerate, zero decelerate
// RQ11: Busy one running; ready zero under alarm
// RQ12: In-position one only when done and held
// RQ13: Phase order selects A or B lead
// RQ14: Gain 0 to 1.0000; zero disables path
// RQ15: Edge counter counts every A/B edge
// RQ16: Signed 32-bit counter; writing zero clears
// RQ17: Count follows direction, wraps two's complement
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sfm_top #(
  parameter int CMD_W = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  output var  logic                       irq,
  input  wire logic [sfm_pkg::IN_W-1:0]   in_pins,
  input  wire logic                       op_busy,
  input  wire logic                       drv_normal,
  input  wire logic                       pos_settled,
  input  wire logic                       target_held,
  output var  logic [sfm_pkg::OUT_W-1:0]  out_pins,
  input  wire logic                       move_step,
  input  wire logic                       move_ccw,
  output var  logic                       phase_a,
  output var  logic                       phase_b,
  input  wire logic signed [CMD_W-1:0]    ff_cmd,
  output var  logic signed [31:0]         ff_out,
  output var  logic                       ff_active,
  input  wire logic                       op_done,
  input  wire logic                       line_editing,
  output var  logic                       tx_valid,
  output var  logic [7:0]                 tx_data,
  input  wire logic                       tx_ready
);
  localparam int IN_W  = sfm_pkg::IN_W;
  localparam int OUT_W = sfm_pkg::OUT_W;
  localparam int TW    = sfm_pkg::TMR_W;

  if (CMD_W < 2 || CMD_W > 17) begin : g_chk
    $error("sfm_top CMD_W must lie in 2..17");
  end

  logic [sfm_pkg::CTRL_W-1:0] ctrl;
  logic [sfm_pkg::GAIN_W-1:0] ff_gain;
  logic [IN_W-1:0]            in_pol;
  logic [TW-1:0]              in_deb;
  logic [OUT_W-1:0]           out_inv;
  logic [TW-1:0]              out_stab;
  logic [sfm_pkg::IRQ_W-1:0]  irq_stat;
  logic [sfm_pkg::IRQ_W-1:0]  irq_mask;
  logic signed [31:0]         edge_cnt;
  logic signed [31:0]         position;
  logic [1:0]                 quad;
  sfm_pkg::sfm_in_s           in_mon;
  sfm_pkg::sfm_out_s          out_mon;
  sfm_pkg::sfm_out_s          out_state;
  sfm_pkg::sfm_cn_e           cn_state;
  sfm_pkg::sfm_cn_e           next_cn_state;
  logic [IN_W-1:0]            in_sync;
  logic [OUT_W-1:0]           out_held;

  wire scale_dir  = ctrl[sfm_pkg::CTRL_SCALE_BIT];
  wire notice_en  = ctrl[sfm_pkg::CTRL_NOTICE_BIT];
  wire phase_ord  = ctrl[sfm_pkg::CTRL_PHASE_BIT];

  // APB decode; a request is taken at the edge where pready is high
  wire acc      = psel & penable;
  wire take     = acc & pready;
  wire wr       = take & pwrite;
  wire a_ctrl   = (paddr == sfm_pkg::ADDR_CTRL);
  wire a_gain   = (paddr == sfm_pkg::ADDR_GAIN);
  wire a_inmon  = (paddr == sfm_pkg::ADDR_IN_MON);
  wire a_outmon = (paddr == sfm_pkg::ADDR_OUT_MON);
  wire a_edge   = (paddr == sfm_pkg::ADDR_EDGE);
  wire a_pos    = (paddr == sfm_pkg::ADDR_POS);
  wire a_istat  = (paddr == sfm_pkg::ADDR_IRQ_STAT);
  wire a_imask  = (paddr == sfm_pkg::ADDR_IRQ_MASK);
  wire a_inpol  = (paddr == sfm_pkg::ADDR_IN_POL);
  wire a_indeb  = (paddr == sfm_pkg::ADDR_IN_DEB);
  wire a_outinv = (paddr == sfm_pkg::ADDR_OUT_INV);
  wire a_stab   = (paddr == sfm_pkg::ADDR_OUT_STAB);
  wire a_ro     = a_inmon | a_outmon | a_pos;
  wire a_rw     = a_ctrl | a_gain | a_edge | a_istat | a_imask | a_inpol
                | a_indeb | a_outinv | a_stab;
  wire gain_bad = a_gain & (pwdata > 32'(sfm_pkg::GAIN_MAX));
  wire next_err = !(a_ro | a_rw) | (pwrite & a_ro) | (pwrite & gain_bad);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_ctrl) begin
      rd_mux = 32'(ctrl);
    end else if (a_gain) begin
      rd_mux = 32'(ff_gain);
    end else if (a_inmon) begin
      rd_mux = 32'(in_mon);
    end else if (a_outmon) begin
      rd_mux = 32'(out_mon);
    end else if (a_edge) begin
      rd_mux = edge_cnt;
    end else if (a_pos) begin
      rd_mux = position;
    end else if (a_istat) begin
      rd_mux = 32'(irq_stat);
    end else if (a_imask) begin
      rd_mux = 32'(irq_mask);
    end else if (a_inpol) begin
      rd_mux = 32'(in_pol);
    end else if (a_indeb) begin
      rd_mux = 32'(in_deb);
    end else if (a_outinv) begin
      rd_mux = 32'(out_inv);
    end else if (a_stab) begin
      rd_mux = 32'(out_stab);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc & !pready;
      pslverr <= acc & !pready & next_err;
      if (acc & !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl     <= sfm_pkg::CTRL_RST;
      ff_gain  <= sfm_pkg::GAIN_RST;
      in_pol   <= sfm_pkg::IN_POL_RST;
      in_deb   <= sfm_pkg::IN_DEB_RST;
      out_inv  <= sfm_pkg::OUT_INV_RST;
      out_stab <= sfm_pkg::OUT_STAB_RST;
      irq_mask <= sfm_pkg::IRQ_MASK_RST;
    end else if (wr) begin
      if (a_ctrl) ctrl <= pwdata[sfm_pkg::CTRL_W-1:0];
      if (a_gain && !gain_bad) ff_gain <= pwdata[sfm_pkg::GAIN_W-1:0];
      if (a_inpol) in_pol <= pwdata[IN_W-1:0];
      if (a_indeb) in_deb <= pwdata[TW-1:0];
      if (a_outinv) out_inv <= pwdata[OUT_W-1:0];
      if (a_stab) out_stab <= pwdata[TW-1:0];
      if (a_imask) irq_mask <= pwdata[sfm_pkg::IRQ_W-1:0];
    end
  end

  // Input conditioning: synchronise, invert, then debounce
  sfm_sync #(.W(IN_W)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (in_pins),
    .q     (in_sync)
  );

  wire [IN_W-1:0] in_cand = in_sync ^ in_pol;
  logic [TW-1:0] deb_cnt [IN_W];

  for (genvar i = 0; i < IN_W; i++) begin : g_deb
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        deb_cnt[i] <= '0;
        in_mon[i]  <= 1'b0;
      end else if (in_cand[i] == in_mon[i]) begin
        deb_cnt[i] <= '0;
      end else if (deb_cnt[i] >= in_deb) begin
        deb_cnt[i] <= '0;
        in_mon[i]  <= in_cand[i]; // see RQ6 see RQ8 see RQ9 see RQ10
      end else begin
        deb_cnt[i] <= deb_cnt[i] + 1'b1;
      end
    end
  end

  // Output monitors take the raw state; pins add stability and inversion
  always_comb begin
    out_state              = '0;
    out_state.in_operation = op_busy; // see RQ11
    out_state.driver_ready = drv_normal; // see RQ11
    out_state.in_position  = pos_settled & target_held; // see RQ12
  end

  logic [TW-1:0] stab_cnt [OUT_W];

  for (genvar j = 0; j < OUT_W; j++) begin : g_stab
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        stab_cnt[j] <= '0;
        out_held[j] <= 1'b0;
      end else if (out_mon[j] == out_held[j]) begin
        stab_cnt[j] <= '0;
      end else if (stab_cnt[j] >= out_stab) begin
        stab_cnt[j] <= '0;
        out_held[j] <= out_mon[j];
      end else begin
        stab_cnt[j] <= stab_cnt[j] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_mon  <= '0;
      out_pins <= '0;
    end else begin
      out_mon  <= out_state; // see RQ7
      out_pins <= out_held ^ out_inv; // see RQ7
    end
  end

  // Position scale, feedback quadrature and edge counter
  wire       pos_up   = move_ccw ~^ scale_dir;
  wire [1:0] next_quad = move_step ? (move_ccw ? quad - 2'h1 : quad + 2'h1)
                                   : quad;
  wire       q_lead   = next_quad[1] ^ next_quad[0];
  wire       q_lag    = next_quad[1];
  wire       clr_edge = wr & a_edge;
  wire       wrap_ev  = move_step & !clr_edge &
                        (move_ccw ? (edge_cnt == 32'sh8000_0000)
                                  : (edge_cnt == 32'sh7FFF_FFFF));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      position <= 32'sh0000_0000;
      quad     <= 2'h0;
      phase_a  <= 1'b0;
      phase_b  <= 1'b0;
      edge_cnt <= 32'sh0000_0000;
    end else begin
      if (move_step) begin
        position <= pos_up ? position + 32'sh1 : position - 32'sh1; // see RQ1
      end
      quad    <= next_quad; // see RQ2
      phase_a <= phase_ord ? q_lag : q_lead; // see RQ13
      phase_b <= phase_ord ? q_lead : q_lag; // see RQ13
      if (clr_edge) begin
        edge_cnt <= pwdata; // see RQ16
      end else if (move_step) begin
        edge_cnt <= move_ccw ? edge_cnt - 32'sh1 : edge_cnt + 32'sh1; // see RQ15 see RQ17
      end
    end
  end

  // Feed-forward: output in units of command times 1/10000
  wire signed [31:0] ff_prod = 32'(ff_cmd) * 32'($signed({1'b0, ff_gain}));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ff_out    <= 32'sh0000_0000;
      ff_active <= 1'b0;
    end else begin
      ff_out    <= (ff_gain == '0) ? 32'sh0000_0000 : ff_prod; // see RQ14
      ff_active <= (ff_gain != '0); // see RQ14
    end
  end

  // Completion notice sequencer
  always_comb begin
    next_cn_state = cn_state;
    case (cn_state)
      sfm_pkg::CN_IDLE: begin
        if (op_done && notice_en) begin // see RQ3
          next_cn_state = line_editing ? sfm_pkg::CN_HOLD : sfm_pkg::CN_SEND;
        end
      end
      sfm_pkg::CN_HOLD: begin
        if (!line_editing) next_cn_state = sfm_pkg::CN_SEND; // see RQ5
      end
      sfm_pkg::CN_SEND: begin
        if (tx_ready) next_cn_state = sfm_pkg::CN_IDLE;
      end
      default: next_cn_state = sfm_pkg::CN_IDLE;
    endcase
  end

  wire sent_ev  = tx_valid & tx_ready;
  wire alarm_ev = out_mon.driver_ready & !out_state.driver_ready;
  wire [sfm_pkg::IRQ_W-1:0] irq_set = {alarm_ev, wrap_ev, sent_ev};
  wire [sfm_pkg::IRQ_W-1:0] irq_clr =
    (wr & a_istat) ? pwdata[sfm_pkg::IRQ_W-1:0] : '0;
  wire [sfm_pkg::IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cn_state <= sfm_pkg::CN_IDLE;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      cn_state <= next_cn_state;
      tx_valid <= (next_cn_state == sfm_pkg::CN_SEND);
      tx_data  <= sfm_pkg::END_CHAR; // see RQ4
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
    end
  end

  // Checks
  AST_POS_DIR: assert property (@(posedge clk) disable iff (!rst_b) // see RQ1
    move_step |=> position == $past(position) +
      (($past(move_ccw) == $past(scale_dir)) ? 32'sh1 : -32'sh1))
    else $error("position moved the wrong way");
  AST_PHASE_STILL: assert property (@(posedge clk) disable iff (!rst_b) // see RQ2
    !move_step && $stable(phase_ord) |=> $stable({phase_a, phase_b}))
    else $error("feedback phase moved without a step");
  AST_NO_NOTICE: assert property (@(posedge clk) disable iff (!rst_b) // see RQ3
    (cn_state == sfm_pkg::CN_IDLE && !notice_en) |=> !tx_valid)
    else $error("notice sent while disabled");
  AST_END_CHAR: assert property (@(posedge clk) disable iff (!rst_b) // see RQ4
    tx_valid |-> tx_data == 8'h21)
    else $error("wrong completion character");
  AST_WAIT_LINE: assert property (@(posedge clk) disable iff (!rst_b) // see RQ5
    $rose(tx_valid) |-> !$past(line_editing))
    else $error("notice sent during line entry");
  AST_OUT_MON: assert property (@(posedge clk) disable iff (!rst_b) // see RQ7
    ##1 out_mon.in_position == $past(pos_settled & target_held))
    else $error("in-position monitor mismatch");
  AST_FF_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // see RQ14
    ff_gain == '0 |=> ff_out == 32'sh0 && !ff_active)
    else $error("feed-forward active at zero gain");
  AST_GAIN_MAX: assert property (@(posedge clk) disable iff (!rst_b) // see RQ14
    ff_gain <= 14'h2710)
    else $error("gain above one");
  AST_EDGE_CNT: assert property (@(posedge clk) disable iff (!rst_b) // see RQ17
    move_step && !clr_edge |=> edge_cnt == $past(edge_cnt) +
      ($past(move_ccw) ? -32'sh1 : 32'sh1))
    else $error("edge counter step wrong");
  AST_EDGE_CLR: assert property (@(posedge clk) disable iff (!rst_b) // see RQ16
    clr_edge && pwdata == 32'h0 |=> edge_cnt == 32'sh0)
    else $error("edge counter not cleared");

  COV_NOTICE: cover property (@(posedge clk) disable iff (!rst_b)
    sent_ev);
  COV_HELD: cover property (@(posedge clk) disable iff (!rst_b)
    cn_state == sfm_pkg::CN_HOLD ##1 cn_state == sfm_pkg::CN_SEND);
  COV_WRAP: cover property (@(posedge clk) disable iff (!rst_b)
    wrap_ev);
  COV_IRQ: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(irq));
endmodule
`default_nettype wire

// >>> tb/sfm_term.sv
// Terminal model: accepts notice characters, may stall, holds line entry
`timescale 1ns/1ps
`default_nettype none
module sfm_term (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic [3:0] stall,
  input  wire logic       editing,
  output var  logic       tx_ready,
  output var  logic       line_editing
);
  logic [3:0] wait_cnt;

  // Accept a character after stall cycles, one cycle pulse
  always @(posedge clk) begin
    if (!rst_b || tx_valid !== 1'h1 || tx_ready) begin
      wait_cnt <= 4'h0;
      tx_ready <= 1'h0;
    end else if (wait_cnt >= stall) begin
      tx_ready <= 1'h1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
    line_editing <= rst_b & editing;
  end
endmodule
`default_nettype wire

// >>> tb/sfm_top_tb.sv
// Self-checking bench for the servo feedback and monitor block
`timescale 1ns/1ps
`default_nettype none
module sfm_top_tb;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } sfm_exp_s;

  logic               clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr, tx_data;
  logic [31:0]        pwdata, prdata;
  logic signed [31:0] ff_out;
  logic signed [15:0] ff_cmd;
  logic [5:0]         in_pins;
  logic [2:0]         out_pins, ctrl;
  logic               irq, op_busy, drv_normal, pos_settled, target_held;
  logic               move_step, move_ccw, phase_a, phase_b, ff_active;
  logic               op_done, line_editing, tx_valid, tx_ready, editing;
  logic [3:0]         stall;
  logic [15:0]        lfsr, r;
  int                 miscompares, checked, qidx, ecnt, pcnt, n;
  sfm_exp_s           e;
  sfm_exp_s           apb_q[$];
  logic [7:0]         tx_q[$];

  sfm_top dut_u (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .in_pins(in_pins),
    .op_busy(op_busy), .drv_normal(drv_normal),
    .pos_settled(pos_settled), .target_held(target_held),
    .out_pins(out_pins), .move_step(move_step), .move_ccw(move_ccw),
    .phase_a(phase_a), .phase_b(phase_b), .ff_cmd(ff_cmd),
    .ff_out(ff_out), .ff_active(ff_active), .op_done(op_done),
    .line_editing(line_editing), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready)
  );

  sfm_term term_u (
    .clk(clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_data(tx_data),
    .stall(stall), .editing(editing), .tx_ready(tx_ready),
    .line_editing(line_editing)
  );

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic check(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_wait();
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  // One APB transfer; the expected answer goes to the queue first
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    apb_q.push_back('{~wr, err, d});
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) fail_wait();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // One feedback step; checks the quadrature pair right after it
  task automatic step(input logic ccw);
    logic [1:0] ab;
    @(posedge clk);
    move_step <= 1'h1;
    move_ccw <= ccw;
    @(posedge clk);
    move_step <= 1'h0;
    ecnt += ccw ? -1 : 1;
    pcnt += (ccw == ctrl[0]) ? 1 : -1;
    qidx = (qidx + (ccw ? 3 : 1)) % 4;
    ab = {qidx == 1 || qidx == 2, qidx >= 2};
    if (ctrl[2]) ab = {ab[0], ab[1]};
    #1;
    check(32'({phase_a, phase_b}), 32'(ab), "phase pair");
  endtask

  task automatic done_pulse();
    @(posedge clk);
    op_done <= 1'h1;
    @(posedge clk);
    op_done <= 1'h0;
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    #1;
    check(32'(irq), 32'(v), "irq level");
  endtask

  // Watcher: compares each answer with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1) begin
      e = apb_q.pop_front();
      check(32'(pslverr), 32'(e.err), "apb error flag");
      if (e.rd) check(prdata, e.data, "apb read data");
    end
    if (tx_valid === 1'h1 && tx_ready) begin
      if (tx_q.size() == 0) check(32'h1, 32'h0, "unexpected notice");
      else check(32'(tx_data), 32'(tx_q.pop_front()), "notice char");
    end
  end

  initial begin
    #2000000;
    fail_wait();
  end

  initial begin
    {rst_b, psel, penable, pwrite, move_step, move_ccw} = 6'h00;
    {op_done, editing, op_busy, pos_settled, target_held} = 5'h00;
    drv_normal = 1'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_pins = 6'h00;
    ff_cmd = 16'h0;
    stall = 4'h0;
    lfsr = 16'h0040;
    {miscompares, checked, qidx, ecnt, pcnt} = '0;
    ctrl = 3'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    apb(1'h0, sfm_pkg::ADDR_CTRL, 32'h0, 1'h0);
    apb(1'h0, sfm_pkg::ADDR_GAIN, 32'h2710, 1'h0);
    apb(1'h0, sfm_pkg::ADDR_IRQ_MASK, 32'h0, 1'h0);
    apb(1'h0, 8'h40, 32'h0, 1'h1);
    apb(1'h1, sfm_pkg::ADDR_OUT_MON, 32'h5, 1'h1);
    for (int g = 0; g < 2; g++) begin
      ctrl = g ? 3'h5 : 3'h0;
      apb(1'h1, sfm_pkg::ADDR_CTRL, 32'(ctrl), 1'h0);
      repeat (8) begin
        r = rnd();
        step(r[0]);
      end
      apb(1'h0, sfm_pkg::ADDR_EDGE, ecnt, 1'h0);
      apb(1'h0, sfm_pkg::ADDR_POS, pcnt, 1'h0);
    end
    apb(1'h1, sfm_pkg::ADDR_EDGE, 32'h7FFFFFFF, 1'h0);
    step(1'h0);
    apb(1'h0, sfm_pkg::ADDR_EDGE, 32'h80000000, 1'h0);
    step(1'h1);
    apb(1'h0, sfm_pkg::ADDR_EDGE, 32'h7FFFFFFF, 1'h0);
    apb(1'h1, sfm_pkg::ADDR_EDGE, 32'h0, 1'h0);
    apb(1'h0, sfm_pkg::ADDR_EDGE, 32'h0, 1'h0);
    apb(1'h0, sfm_pkg::ADDR_IRQ_STAT, 32'h2, 1'h0);
    irq_is(1'h0);
    apb(1'h1, sfm_pkg::ADDR_IRQ_MASK, 32'h3, 1'h0);
    irq_is(1'h1);
    apb(1'h1, sfm_pkg::ADDR_IRQ_STAT, 32'h2, 1'h0);
    irq_is(1'h0);
    // Completion arrives during line entry and must wait for its end
    apb(1'h1, sfm_pkg::ADDR_CTRL, 32'h2, 1'h0);
    editing <= 1'h1;
    stall <= 4'h3;
    done_pulse();
    repeat (6) @(posedge clk);
    #1;
    check(32'(tx_valid), 32'h0, "notice held back");
    tx_q.push_back(8'h21);
    @(posedge clk);
    editing <= 1'h0;
    n = 0;
    while (tx_q.size() != 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (tx_q.size() != 0) fail_wait();
    irq_is(1'h1);
    apb(1'h0, sfm_pkg::ADDR_IRQ_STAT, 32'h1, 1'h0);
    apb(1'h1, sfm_pkg::ADDR_IRQ_STAT, 32'h1, 1'h0);
    apb(1'h1, sfm_pkg::ADDR_CTRL, 32'h0, 1'h0);
    done_pulse();
    repeat (10) @(posedge clk);
    r = rnd();
    ff_cmd <= r;
    apb(1'h1, sfm_pkg::ADDR_GAIN, 32'h0, 1'h0);
    repeat (3) @(posedge clk);
    #1;
    check(32'(ff_active), 32'h0, "ff off");
    check(ff_out, 32'h0, "ff zero");
    apb(1'h1, sfm_pkg::ADDR_GAIN, 32'h1388, 1'h0);
    repeat (3) @(posedge clk);
    #1;
    check(ff_out, 32'(ff_cmd) * 32'sh1388, "ff product");
    check(32'(ff_active), 32'h1, "ff on");
    apb(1'h1, sfm_pkg::ADDR_GAIN, 32'h2711, 1'h1);
    apb(1'h0, sfm_pkg::ADDR_GAIN, 32'h1388, 1'h0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      in_pins <= r[5:0];
      {op_busy, drv_normal, pos_settled, target_held} <= r[9:6];
      apb(1'h1, sfm_pkg::ADDR_IN_POL, 32'(r[15:10]), 1'h0);
      apb(1'h1, sfm_pkg::ADDR_OUT_INV, 32'(r[12:10]), 1'h0);
      apb(1'h1, sfm_pkg::ADDR_IN_DEB, 32'(i), 1'h0);
      apb(1'h1, sfm_pkg::ADDR_OUT_STAB, 32'(i), 1'h0);
      repeat (20) @(posedge clk);
      apb(1'h0, sfm_pkg::ADDR_IN_MON, 32'(r[5:0] ^ r[15:10]),
          1'h0);
      apb(1'h0, sfm_pkg::ADDR_OUT_MON, 32'({r[7] & r[6], r[8], r[9]}),
          1'h0);
      #1;
      check(32'(out_pins), 32'({r[7] & r[6], r[8], r[9]} ^ r[12:10]),
            "output pins");
    end
    complete_run();
  end
endmodule
`default_nettype wire
